// *** hdl/cmaf_defines.vh ***
`ifndef CMAF_DEFINES_VH
`define CMAF_DEFINES_VH

// Clock rate and timing figures
`define CMAF_CLK_HZ 20000000
`define CMAF_PWRUP_US 500
`define CMAF_PWRUP_CYC ((`CMAF_PWRUP_US * (`CMAF_CLK_HZ / 1000000)) + 1)
`define CMAF_CONV_STEP_US 6
`define CMAF_CONV_STEP_CYC (`CMAF_CONV_STEP_US * (`CMAF_CLK_HZ / 1000000))
`define CMAF_UV_DELAY_MS 1000
`define CMAF_UV_DELAY_CYC (`CMAF_UV_DELAY_MS * (`CMAF_CLK_HZ / 1000))

// Converter layout
`define CMAF_ADC_BITS 14
`define CMAF_NUM_CELLS 6
`define CMAF_NUM_TEMPS 2
`define CMAF_NUM_SRC 9
`define CMAF_SRC_GPAI 8

`endif

// *** hdl/cmaf_result_mem.v ***
`timescale 1ns/10ps
`default_nettype none

module cmaf_result_mem #(
  parameter DW = 14,
  parameter AW = 4,
  parameter DEPTH = 9
) (
  input wire clk, // Clock
  input wire we, // Write strobe
  input wire [AW-1:0] waddr, // Write address
  input wire [DW-1:0] wdata, // Write data
  input wire [AW-1:0] raddr, // Read address
  output reg [DW-1:0] rdata_reg // Registered read data
);

  reg [DW-1:0] mem [0:DEPTH-1];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_reg <= mem[raddr];
  end

endmodule

`default_nettype wire

// *** hdl/cmaf_monitor.v ***
`timescale 1ns/10ps
`default_nettype none
`include "cmaf_defines.vh"

// Function
// - Protection compares run apart from the converter, needing no conversion activity.
// - Faults appear on a dedicated output pin, not through the host bus.
// - Fault asserts when any cell exceeds the over-voltage threshold.
// - Fault asserts after a cell stays under-voltage for the detection delay.
// - Separate alert output serves over-temperature on two temperature channels.
// - Alert asserts once a temperature exceeds the over-temperature threshold.
// - Conversion takes six microseconds per channel plus six microseconds start.
// - Power control bit set keeps converter and reference powered.
// - With converter powered, a commanded conversion starts without power-up delay.
// - With power bit clear, a command powers up automatically, adding 500 microseconds.
// - Automatic mode powers down after every conversion, so each pays power-up.
// - 14-bit converter multiplexes six cells, two temperatures, one general analog input.
module cmaf_monitor #(
  parameter NCELL = `CMAF_NUM_CELLS,
  parameter NTEMP = `CMAF_NUM_TEMPS,
  parameter NSRC = `CMAF_NUM_SRC,
  parameter DW = `CMAF_ADC_BITS,
  parameter PWRUP_CYC = `CMAF_PWRUP_CYC,
  parameter STEP_CYC = `CMAF_CONV_STEP_CYC,
  parameter UV_DELAY_CYC = `CMAF_UV_DELAY_CYC
) (
  input wire clk, // 20 MHz clock
  input wire nrst, // Synchronous reset, active low
  input wire [NCELL*DW-1:0] cell_level, // Protection comparator cell levels
  input wire [NTEMP*DW-1:0] temp_level, // Protection comparator temperatures
  input wire [DW-1:0] ov_threshold, // Over-voltage threshold
  input wire [DW-1:0] uv_threshold, // Under-voltage threshold
  input wire [DW-1:0] ot_threshold, // Over-temperature threshold
  input wire adc_on, // Converter power control bit
  input wire conv_start, // Conversion command, pin
  input wire [3:0] conv_count, // Sources to convert, 1..9
  input wire [DW-1:0] adc_sample, // Converter sample at end of step
  input wire [3:0] result_sel, // Result index to read
  output reg fault_reg, // Fault output pin
  output reg alert_reg, // Alert output pin
  output reg adc_power_reg, // Converter and reference powered
  output reg [3:0] mux_sel_reg, // Converter input select
  output reg busy_reg, // Sequence in progress
  output reg conv_done_reg, // Sequence done, held until next command
  output reg [DW-1:0] result_reg // Selected conversion result
);

  // ----------------------------------------
  // States and widths
  // ----------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_PWRUP = 2'b01;
  localparam ST_OVH = 2'b10;
  localparam ST_CONV = 2'b11;
  localparam CW = 25;
  localparam UW = 26;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Out-of-range requests are folded into range rather than refused
  function [3:0] clamp_count;
    input [3:0] req;
    begin
      if (req == 4'h0) begin
        clamp_count = 4'h1;
      end else if (req > NSRC[3:0]) begin
        clamp_count = NSRC[3:0];
      end else begin
        clamp_count = req;
      end
    end
  endfunction

  // Timer counts down to zero, so a span of N cycles loads N-1
  function [CW-1:0] load_of;
    input [CW-1:0] cycles;
    begin
      load_of = cycles - {{(CW-1){1'b0}}, 1'b1};
    end
  endfunction

  function above;
    input [DW-1:0] lvl;
    input [DW-1:0] lim;
    begin
      above = (lvl > lim);
    end
  endfunction

  function below;
    input [DW-1:0] lvl;
    input [DW-1:0] lim;
    begin
      below = (lvl < lim);
    end
  endfunction

  function is_last;
    input [3:0] sel;
    input [3:0] total;
    begin
      is_last = ((sel + 4'h1) >= total);
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [2:0] start_s1_reg;
  reg [2:0] start_s2_reg;
  reg start_prev_reg;
  reg [3:0] count_s1_reg;
  reg [3:0] count_s2_reg;
  // Count travels through the same two stages as the start pin, so both line up
  always @(posedge clk) begin
    if (!nrst) begin
      start_s1_reg <= 3'h0;
      start_s2_reg <= 3'h0;
      start_prev_reg <= 1'b0;
      count_s1_reg <= 4'h0;
      count_s2_reg <= 4'h0;
    end else begin
      start_s1_reg <= {adc_on, conv_start, 1'b0};
      start_s2_reg <= start_s1_reg;
      start_prev_reg <= start_s2_reg[1];
      count_s1_reg <= conv_count;
      count_s2_reg <= count_s1_reg;
    end
  end
  wire on_sync = start_s2_reg[2];
  wire start_pulse = start_s2_reg[1] & ~start_prev_reg;

  // ----------------------------------------
  // Protection path
  // ----------------------------------------
  // The comparators read their own inputs only; no converter state is used.
  reg [NCELL-1:0] ov_hit;
  reg [NCELL-1:0] uv_hit;
  reg [NTEMP-1:0] ot_hit;
  genvar g;
  generate
    for (g = 0; g < NCELL; g = g + 1) begin : g_cell
      always @* begin
        ov_hit[g] = above(cell_level[g*DW +: DW], ov_threshold);
        uv_hit[g] = below(cell_level[g*DW +: DW], uv_threshold);
      end
    end
    for (g = 0; g < NTEMP; g = g + 1) begin : g_temp
      always @* begin
        ot_hit[g] = above(temp_level[g*DW +: DW], ot_threshold);
      end
    end
  endgenerate

  reg [UW-1:0] uv_cnt_reg;
  wire uv_expired = (uv_cnt_reg >= UV_DELAY_CYC[UW-1:0]);
  always @(posedge clk) begin
    if (!nrst) begin
      uv_cnt_reg <= {UW{1'b0}};
    end else begin
      // The delay restarts only once no cell is under-voltage
      if (|uv_hit) begin
        // Saturates so a long under-voltage never wraps back below the delay
        if (uv_cnt_reg < UV_DELAY_CYC[UW-1:0]) begin
          uv_cnt_reg <= uv_cnt_reg + 1'b1;
        end
      end else begin
        uv_cnt_reg <= {UW{1'b0}};
      end
    end
  end

  // ----------------------------------------
  // Protection outputs
  // ----------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      fault_reg <= 1'b0;
      alert_reg <= 1'b0;
    end else begin
      fault_reg <= (|ov_hit) | uv_expired;
      alert_reg <= |ot_hit;
    end
  end

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  reg [1:0] state_reg;
  reg [CW-1:0] timer_reg;
  reg [3:0] nconv_reg;
  reg auto_reg;
  reg mem_we_reg;
  reg [3:0] mem_waddr_reg;
  reg [DW-1:0] mem_wdata_reg;
  wire [DW-1:0] mem_rdata;
  wire timer_end = (timer_reg == {CW{1'b0}});
  wire [3:0] count_lim = clamp_count(count_s2_reg);

  always @(posedge clk) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      timer_reg <= {CW{1'b0}};
      nconv_reg <= 4'h0;
      auto_reg <= 1'b0;
      mux_sel_reg <= 4'h0;
      busy_reg <= 1'b0;
      conv_done_reg <= 1'b0;
      adc_power_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_waddr_reg <= 4'h0;
      mem_wdata_reg <= {DW{1'b0}};
    end else begin
      mem_we_reg <= 1'b0;
      if (!timer_end) begin
        timer_reg <= timer_reg - 1'b1;
      end
      case (state_reg)
        ST_IDLE: begin
          adc_power_reg <= on_sync;
          if (start_pulse) begin
            busy_reg <= 1'b1;
            conv_done_reg <= 1'b0;
            nconv_reg <= count_lim;
            mux_sel_reg <= 4'h0;
            adc_power_reg <= 1'b1;
            if (on_sync) begin
              // Already powered: go straight to overhead
              auto_reg <= 1'b0;
              timer_reg <= load_of(STEP_CYC[CW-1:0]);
              state_reg <= ST_OVH;
            end else begin
              auto_reg <= 1'b1;
              timer_reg <= load_of(PWRUP_CYC[CW-1:0]);
              state_reg <= ST_PWRUP;
            end
          end
        end
        ST_PWRUP: begin
          if (timer_end) begin
            timer_reg <= load_of(STEP_CYC[CW-1:0]);
            state_reg <= ST_OVH;
          end
        end
        ST_OVH: begin
          if (timer_end) begin
            timer_reg <= load_of(STEP_CYC[CW-1:0]);
            state_reg <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (timer_end) begin
            mem_we_reg <= 1'b1;
            mem_waddr_reg <= mux_sel_reg;
            mem_wdata_reg <= adc_sample;
            if (is_last(mux_sel_reg, nconv_reg)) begin
              busy_reg <= 1'b0;
              conv_done_reg <= 1'b1;
              // Auto mode drops power; manual keeps it while the bit stays set
              adc_power_reg <= auto_reg ? 1'b0 : on_sync;
              state_reg <= ST_IDLE;
            end else begin
              mux_sel_reg <= mux_sel_reg + 4'h1;
              timer_reg <= load_of(STEP_CYC[CW-1:0]);
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Results
  // ----------------------------------------
  cmaf_result_mem #(
    .DW(DW),
    .AW(4),
    .DEPTH(NSRC)
  ) u_mem (
    .clk(clk),
    .we(mem_we_reg),
    .waddr(mem_waddr_reg),
    .wdata(mem_wdata_reg),
    .raddr(result_sel),
    .rdata_reg(mem_rdata)
  );

  always @(posedge clk) begin
    if (!nrst) begin
      result_reg <= {DW{1'b0}};
    end else begin
      result_reg <= mem_rdata;
    end
  end

endmodule

`default_nettype wire

// *** tb/cmaf_host.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------
// Host model
// ----------
module cmaf_host #(parameter PWRUP_CYC = 20) (
  input wire logic clk, // Clock
  input wire logic done, // Sequence done
  output logic adc_on, // Power bit
  output logic conv_start, // Start pin
  output logic [3:0] conv_count // Sources
);
  initial begin
    adc_on = 1'h0;
    conv_start = 1'h0;
    conv_count = 4'h1;
  end
  task automatic run(input logic man, input logic [3:0] n);
    @(negedge clk);
    adc_on = man;
    conv_count = n;
    if (man) repeat (PWRUP_CYC + 2) @(negedge clk);
    conv_start = 1'h1;
    // Held past the synchroniser so the old done flag has cleared
    repeat (6) @(negedge clk);
    conv_start = 1'h0;
    for (int j = 0; j < 300 && !done; j++) @(negedge clk);
    adc_on = 1'h0;
  endtask
endmodule
`default_nettype wire

// *** tb/cmaf_monitor_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module cmaf_chk #(parameter UV_DELAY_CYC = 50) (
  input wire logic clk, // Clock
  input wire logic nrst, // Reset
  input wire logic [83:0] cell_level, // Cells
  input wire logic [27:0] temp_level, // Temps
  input wire logic [13:0] ov_threshold, // OV
  input wire logic [13:0] uv_threshold, // UV
  input wire logic [13:0] ot_threshold, // OT
  input wire logic adc_on, // Power bit
  input wire logic fault_reg, // Fault
  input wire logic alert_reg, // Alert
  input wire logic adc_power_reg, // Power
  input wire logic busy_reg, // Busy
  input wire logic conv_done_reg // Done
);
  logic ov, uv, ot;
  logic [31:0] uvc;
  always_comb begin
    ov = 1'h0;
    uv = 1'h0;
    ot = 1'h0;
    for (int i = 0; i < 6; i++) begin
      ov |= cell_level[i*14+:14] > ov_threshold;
      uv |= cell_level[i*14+:14] < uv_threshold;
    end
    for (int i = 0; i < 2; i++) ot |= temp_level[i*14+:14] > ot_threshold;
  end
  // Saturates so a long undervoltage cannot wrap back below the delay
  always_ff @(posedge clk) begin
    if (!nrst || !uv) uvc <= 32'h0;
    else if (uvc < UV_DELAY_CYC + 4) uvc <= uvc + 32'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_ov_fault: assert property ($past(nrst) && ov |=> fault_reg) else $error("no fault on ov");
  a_fault_cause: assert property ($rose(fault_reg) |-> $past(ov) || $past(uv)) else $error("stray fault");
  a_uv_late: assert property (uvc == UV_DELAY_CYC + 4 |-> fault_reg) else $error("no uv fault");
  a_ot_alert: assert property ($past(nrst) && ot |=> alert_reg) else $error("no alert on ot");
  a_busy_power: assert property (busy_reg |-> adc_power_reg) else $error("busy unpowered");
  a_manual_on: assert property (adc_on [*4] |=> adc_power_reg) else $error("power bit ignored");
  a_auto_off: assert property ($fell(busy_reg) && !adc_on && !$past(adc_on, 4) |-> ##[0:1] !adc_power_reg)
    else $error("auto power stays on");
  a_done_flag: assert property ($fell(busy_reg) |-> conv_done_reg) else $error("no done flag");
endmodule
bind cmaf_monitor cmaf_chk #(.UV_DELAY_CYC(UV_DELAY_CYC)) u_chk (.clk(clk), .nrst(nrst),
  .cell_level(cell_level), .temp_level(temp_level), .ov_threshold(ov_threshold),
  .uv_threshold(uv_threshold), .ot_threshold(ot_threshold), .adc_on(adc_on), .fault_reg(fault_reg),
  .alert_reg(alert_reg), .adc_power_reg(adc_power_reg), .busy_reg(busy_reg), .conv_done_reg(conv_done_reg));
`default_nettype wire

// *** tb/cell_monitor_adc_and_fault_signaling_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module cell_monitor_adc_and_fault_signaling_tb_top;
  logic clk = 1'h0, nrst = 1'h0;
  logic [83:0] cl = 84'h0;
  logic [27:0] tl = 28'h0;
  logic [13:0] ovt = 14'h3000, uvt = 14'h0000, ott = 14'h2000;
  logic [3:0] rs = 4'h0;
  wire on, st, fr, ar, pw, by, dn;
  wire [3:0] cc, mx;
  wire [13:0] rr;
  int err_total = 0, compares = 0, bl = 0;
  always #25 clk = ~clk;
  always @(posedge clk) if (by) bl <= bl + 1;
  cmaf_monitor #(.PWRUP_CYC(20), .STEP_CYC(4), .UV_DELAY_CYC(50)) dut (.clk(clk), .nrst(nrst),
    .cell_level(cl), .temp_level(tl), .ov_threshold(ovt), .uv_threshold(uvt), .ot_threshold(ott),
    .adc_on(on), .conv_start(st), .conv_count(cc), .adc_sample({mx, 10'h2A5}), .result_sel(rs),
    .fault_reg(fr), .alert_reg(ar), .adc_power_reg(pw), .mux_sel_reg(mx), .busy_reg(by),
    .conv_done_reg(dn), .result_reg(rr));
  cmaf_host #(.PWRUP_CYC(20)) host (.clk(clk), .done(dn), .adc_on(on), .conv_start(st), .conv_count(cc));
  task chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task close_out;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function logic [1:0] pexp;
    pexp = 2'h0;
    for (int i = 0; i < 6; i++) if (cl[i*14+:14] > ovt) pexp[1] = 1'h1;
    for (int i = 0; i < 2; i++) if (tl[i*14+:14] > ott) pexp[0] = 1'h1;
  endfunction
  function int nclamp(input logic [3:0] n);
    nclamp = (n == 4'h0) ? 1 : (n > 4'h9 ? 9 : n);
  endfunction
  task conv(input logic m, input logic [3:0] n);
    bl = 0;
    host.run(m, n);
    chk(16'(bl), 16'(4 * (nclamp(n) + 1) + (m ? 0 : 20)));
    for (int i = 0; i < nclamp(n); i++) begin
      rs = i[3:0];
      repeat (3) @(negedge clk);
      chk({2'h0, rr}, {2'h0, i[3:0], 10'h2A5});
    end
  endtask
  initial begin
    void'($urandom(12));
    repeat (4) @(negedge clk);
    nrst = 1'h1;
    repeat (30) begin
      cl = 84'({$urandom, $urandom, $urandom});
      tl = 28'($urandom);
      repeat (2) @(negedge clk);
      chk({14'h0, fr, ar}, {14'h0, pexp()});
    end
    conv(1'h1, 4'h9);
    conv(1'h0, 4'h0);
    conv(1'h0, 4'hF);
    repeat (4) conv(1'($urandom), 4'($urandom));
    cl = {{5{14'h1000}}, 14'h0100};
    uvt = 14'h0800;
    repeat (45) @(negedge clk);
    chk({15'h0, fr}, 16'h0000);
    repeat (12) @(negedge clk);
    chk({15'h0, fr}, 16'h0001);
    close_out;
  end
  // Generous bound: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out;
  end
endmodule
`default_nettype wire
